/* rtl/cmsns_defines.svh */
`ifndef CMSNS_DEFINES_SVH
`define CMSNS_DEFINES_SVH

// Byte addresses of the register map
`define CMSNS_REQ_BASE      9'h000
`define CMSNS_REQ_LAST      9'h010
`define CMSNS_RESP_BASE     9'h020
`define CMSNS_RESP_LAST     9'h034
`define CMSNS_CTRL_ADDR     9'h040
`define CMSNS_MSTATE_ADDR   9'h044
`define CMSNS_VERSION_ADDR  9'h048
`define CMSNS_BITRATE_ADDR  9'h04c
`define CMSNS_FLAGS_BASE    9'h050
`define CMSNS_FLAGS_LAST    9'h05c
`define CMSNS_ERR_BASE      9'h100

// Control register fields
`define CMSNS_CTRL_EN_BIT   0
`define CMSNS_CTRL_BUSY_BIT 1

// Reset values
`define CMSNS_CTRL_RESET    1'b0
`define CMSNS_TAG_RESET     8'h00

// Arbitrary protocol revision value
`define CMSNS_PROTO_VERSION 16'h0001

// Response status codes
`define CMSNS_STATUS_OK     8'h01
`define CMSNS_STATUS_ABORT  8'h00

// Node error codes
`define CMSNS_ERR_NONE      8'h00
`define CMSNS_ERR_EMCY      8'he0
`define CMSNS_ERR_PDO_LEN   8'he1
`define CMSNS_ERR_PDO_MISS  8'he2
`define CMSNS_ERR_AUTO_SDO  8'he3
`define CMSNS_ERR_PDO_CFG   8'he4
`define CMSNS_ERR_KEY_PARAM 8'he5
`define CMSNS_ERR_ABSENT    8'he6
`define CMSNS_ERR_GUARD     8'he7
`define CMSNS_ERR_DUP_ID    8'he8

// Supervised node count
`define CMSNS_NODES         7'd64

// AXI responses
`define CMSNS_RESP_OKAY     2'b00
`define CMSNS_RESP_SLVERR   2'b10

`endif

/* rtl/cmsns_pkg.sv */
package cmsns_pkg;

    typedef enum logic [1:0] {
        SDO_IDLE,
        SDO_SEND,
        SDO_WAIT
    } cmsns_sdo_st_t;

    typedef struct packed {
        logic             aw_have;
        logic [8:0]       aw_addr;
        logic             w_have;
        logic [31:0]      w_data;
        logic [3:0]       w_strb;
        logic             b_valid;
        logic [1:0]       b_resp;
        logic             r_valid;
        logic [31:0]      r_data;
        logic [1:0]       r_resp;
        logic [4:0][15:0] req;
        logic [5:0][15:0] resp;
        logic             enable;
        logic [7:0]       last_tag;
        cmsns_sdo_st_t    sdo;
        logic             req_valid;
    } cmsns_top_st_t;

    typedef struct packed {
        logic [63:0][7:0] code;
    } cmsns_node_st_t;

endpackage

/* rtl/cmsns_node_sup.sv */
`timescale 1ns/1ps
`include "cmsns_defines.svh"

module cmsns_node_sup (
    input  wire logic             clock,
    input  wire logic             rst_sync_b,
    input  wire logic             enable,
    input  wire logic             ev_valid,
    input  wire logic [6:0]       ev_node,
    input  wire logic [7:0]       ev_code,
    input  wire logic [63:0]      node_configured,
    output logic      [63:0][7:0] node_codes,
    output logic      [63:0]      node_flags
);

    cmsns_pkg::cmsns_node_st_t st_reg;
    cmsns_pkg::cmsns_node_st_t st_next;
    logic                      code_ok;
    logic [5:0]                ev_idx;

    assign ev_idx = 6'(ev_node - 7'd1);

    always_comb begin
        case (ev_code)
            `CMSNS_ERR_NONE:      code_ok = 1'b1;
            `CMSNS_ERR_EMCY:      code_ok = 1'b1;
            `CMSNS_ERR_PDO_LEN:   code_ok = 1'b1;
            `CMSNS_ERR_PDO_MISS:  code_ok = 1'b1;
            `CMSNS_ERR_AUTO_SDO:  code_ok = 1'b1;
            `CMSNS_ERR_PDO_CFG:   code_ok = 1'b1;
            `CMSNS_ERR_KEY_PARAM: code_ok = 1'b1;
            `CMSNS_ERR_ABSENT:    code_ok = 1'b1;
            `CMSNS_ERR_GUARD:     code_ok = 1'b1;
            `CMSNS_ERR_DUP_ID:    code_ok = 1'b1;
            default:              code_ok = 1'b0;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        if (enable && ev_valid && code_ok && ev_node != 7'd0 && ev_node <= `CMSNS_NODES) begin
            st_next.code[ev_idx] = ev_code;
        end
        for (int i = 0; i < 64; i++) begin
            if (!enable || !node_configured[i]) begin
                st_next.code[i] = `CMSNS_ERR_NONE;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    assign node_codes = st_reg.code;

    genvar g;
    generate
        for (g = 0; g < 64; g++) begin : g_flag
            assign node_flags[g] = (st_reg.code[g] != `CMSNS_ERR_NONE);
        end
    endgenerate

    a_emcy_loads: assert property (@(posedge clock) disable iff (!rst_sync_b)
        enable && ev_valid && ev_code == 8'he0 && ev_node == 7'd1 && node_configured[0]
        |=> node_codes[0] == 8'he0 && node_flags[0])
        else $error("emergency code not loaded");
    a_guard_loads: assert property (@(posedge clock) disable iff (!rst_sync_b)
        enable && ev_valid && ev_code == 8'he7 && ev_node == 7'd63 && node_configured[62]
        |=> node_codes[62] == 8'he7 && node_flags[62])
        else $error("guard timeout code not loaded");
    a_range_ignored: assert property (@(posedge clock) disable iff (!rst_sync_b)
        enable && ev_valid && (ev_node == 7'd0 || ev_node > 7'd64) && node_configured[0]
        |=> $stable(node_codes[0]))
        else $error("out of range node changed a code");
    a_unconfig_zero: assert property (@(posedge clock) disable iff (!rst_sync_b)
        !node_configured[63] |=> node_codes[63] == 8'h00 && !node_flags[63])
        else $error("unconfigured node holds a code");
    a_disable_clears: assert property (@(posedge clock) disable iff (!rst_sync_b)
        !enable [*2] |-> node_flags == 64'h0)
        else $error("flags set while supervision disabled");
    a_flag_code: assert property (@(posedge clock) disable iff (!rst_sync_b)
        enable && ev_valid && ev_node == 7'd16 && ev_code == 8'h00 |=> !node_flags[15])
        else $error("flag not cleared with code");

endmodule

/* rtl/cmsns_top.sv */
`timescale 1ns/1ps
`include "cmsns_defines.svh"

module cmsns_top (
    input  wire logic        clock,
    input  wire logic        rst_b,
    input  wire logic [8:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [8:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output logic             sdo_req_valid,
    input  wire logic        sdo_req_ready,
    output logic [7:0]       sdo_req_tag,
    output logic [7:0]       sdo_req_command,
    output logic [7:0]       sdo_req_size,
    output logic [7:0]       sdo_req_type,
    output logic [7:0]       sdo_req_node,
    output logic [15:0]      sdo_req_index,
    output logic [7:0]       sdo_req_subindex,
    input  wire logic        sdo_resp_valid,
    input  wire logic [7:0]  sdo_resp_status,
    input  wire logic [7:0]  sdo_resp_size,
    input  wire logic [7:0]  sdo_resp_type,
    input  wire logic [15:0] sdo_resp_data,
    input  wire logic        node_ev_valid,
    input  wire logic [6:0]  node_ev_node,
    input  wire logic [7:0]  node_ev_code,
    input  wire logic [63:0] node_configured,
    input  wire logic [15:0] master_state_code,
    input  wire logic [15:0] bit_rate_kbps,
    output logic             canopen_enabled
);

    cmsns_pkg::cmsns_top_st_t st_reg;
    cmsns_pkg::cmsns_top_st_t st_next;
    logic                     rst_meta_b;
    logic                     rst_sync_b;
    logic [63:0][7:0]         node_codes;
    logic [63:0]              node_flags;
    logic [31:0]              rd_word;
    logic [1:0]               rd_resp;
    logic [15:0]              wr_merge;
    logic [8:0]               wa;
    logic [2:0]               wa_idx;
    logic                     busy;

    // Reset release through two flops
    always_ff @(posedge clock or negedge rst_b) begin
        if (!rst_b) begin
            rst_meta_b <= 1'b0;
            rst_sync_b <= 1'b0;
        end else begin
            rst_meta_b <= 1'b1;
            rst_sync_b <= rst_meta_b;
        end
    end

    cmsns_node_sup u_node_sup (
        .clock           (clock),
        .rst_sync_b      (rst_sync_b),
        .enable          (st_reg.enable),
        .ev_valid        (node_ev_valid),
        .ev_node         (node_ev_node),
        .ev_code         (node_ev_code),
        .node_configured (node_configured),
        .node_codes      (node_codes),
        .node_flags      (node_flags)
    );

    assign busy = (st_reg.sdo != cmsns_pkg::SDO_IDLE);
    assign wa = st_reg.aw_addr;
    assign wa_idx = wa[4:2];
    assign wr_merge = {st_reg.w_strb[1] ? st_reg.w_data[15:8] : st_reg.req[wa_idx][15:8],
                       st_reg.w_strb[0] ? st_reg.w_data[7:0] : st_reg.req[wa_idx][7:0]};

    // Read decode
    always_comb begin
        rd_word = 32'h0000_0000;
        rd_resp = `CMSNS_RESP_OKAY;
        if (s_axi_araddr[1:0] != 2'b00) begin
            rd_resp = `CMSNS_RESP_SLVERR;
        end else if (s_axi_araddr[8]) begin
            rd_word = {24'h00_0000, node_codes[s_axi_araddr[7:2]]};
        end else if (s_axi_araddr <= `CMSNS_REQ_LAST) begin
            rd_word = {16'h0000, st_reg.req[s_axi_araddr[4:2]]};
        end else if (s_axi_araddr >= `CMSNS_RESP_BASE && s_axi_araddr <= `CMSNS_RESP_LAST) begin
            rd_word = {16'h0000, st_reg.resp[3'(s_axi_araddr[5:2] - 4'd8)]};
        end else if (s_axi_araddr == `CMSNS_CTRL_ADDR) begin
            rd_word[`CMSNS_CTRL_EN_BIT] = st_reg.enable;
            rd_word[`CMSNS_CTRL_BUSY_BIT] = busy;
        end else if (s_axi_araddr == `CMSNS_MSTATE_ADDR) begin
            rd_word = {16'h0000, st_reg.enable ? master_state_code : 16'h0000};
        end else if (s_axi_araddr == `CMSNS_VERSION_ADDR) begin
            rd_word = {16'h0000, `CMSNS_PROTO_VERSION};
        end else if (s_axi_araddr == `CMSNS_BITRATE_ADDR) begin
            rd_word = {16'h0000, bit_rate_kbps};
        end else if (s_axi_araddr >= `CMSNS_FLAGS_BASE && s_axi_araddr <= `CMSNS_FLAGS_LAST) begin
            rd_word = {16'h0000, node_flags[s_axi_araddr[3:2]*16 +: 16]};
        end else begin
            rd_resp = `CMSNS_RESP_SLVERR;
        end
    end

    always_comb begin
        st_next = st_reg;

        // Address and data may arrive in either order
        if (s_axi_awvalid && s_axi_awready) begin
            st_next.aw_have = 1'b1;
            st_next.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            st_next.w_have = 1'b1;
            st_next.w_data = s_axi_wdata;
            st_next.w_strb = s_axi_wstrb;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            st_next.b_valid = 1'b0;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            st_next.r_valid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            st_next.r_valid = 1'b1;
            st_next.r_data = rd_word;
            st_next.r_resp = rd_resp;
        end

        // SDO transaction sequencing
        case (st_reg.sdo)
            cmsns_pkg::SDO_SEND: begin
                if (sdo_req_ready) begin
                    st_next.req_valid = 1'b0;
                    st_next.sdo = cmsns_pkg::SDO_WAIT;
                end
            end
            cmsns_pkg::SDO_WAIT: begin
                if (sdo_resp_valid && st_reg.enable) begin
                    st_next.sdo = cmsns_pkg::SDO_IDLE;
                    st_next.resp[0] = {st_reg.last_tag, sdo_resp_status};
                    if (sdo_resp_status == `CMSNS_STATUS_OK) begin
                        st_next.resp[1] = {8'h00, sdo_resp_size};
                        st_next.resp[2] = {sdo_resp_type, st_reg.req[2][7:0]};
                        st_next.resp[3] = st_reg.req[3];
                        st_next.resp[4] = {8'h00, st_reg.req[4][7:0]};
                        st_next.resp[5] = sdo_resp_data;
                    end
                end
            end
            default: begin
            end
        endcase

        // Disabling aborts an open transaction as a failure
        if (!st_reg.enable && busy) begin
            st_next.sdo = cmsns_pkg::SDO_IDLE;
            st_next.req_valid = 1'b0;
            st_next.resp[0] = {st_reg.last_tag, `CMSNS_STATUS_ABORT};
        end

        // Register write once both halves are held
        if (st_reg.aw_have && st_reg.w_have && !st_reg.b_valid) begin
            st_next.aw_have = 1'b0;
            st_next.w_have = 1'b0;
            st_next.b_valid = 1'b1;
            st_next.b_resp = `CMSNS_RESP_OKAY;
            if (wa[1:0] != 2'b00) begin
                st_next.b_resp = `CMSNS_RESP_SLVERR;
            end else if (wa <= `CMSNS_REQ_LAST) begin
                // Request words frozen while a transaction is open
                if (!busy) begin
                    st_next.req[wa_idx] = wr_merge;
                    if (wa_idx == 3'd0 && st_reg.enable && wr_merge[15:8] != st_reg.last_tag) begin
                        st_next.last_tag = wr_merge[15:8];
                        st_next.sdo = cmsns_pkg::SDO_SEND;
                        st_next.req_valid = 1'b1;
                    end
                end
            end else if (wa == `CMSNS_CTRL_ADDR) begin
                if (st_reg.w_strb[0]) begin
                    st_next.enable = st_reg.w_data[`CMSNS_CTRL_EN_BIT];
                end
            end else if (wa >= `CMSNS_RESP_BASE && wa <= `CMSNS_FLAGS_LAST) begin
                st_next.b_resp = `CMSNS_RESP_OKAY;
            end else if (wa[8]) begin
                st_next.b_resp = `CMSNS_RESP_OKAY;
            end else begin
                st_next.b_resp = `CMSNS_RESP_SLVERR;
            end
        end
    end

    always_ff @(posedge clock or negedge rst_sync_b) begin
        if (!rst_sync_b) begin
            st_reg <= '0;
            st_reg.enable <= `CMSNS_CTRL_RESET;
            st_reg.last_tag <= `CMSNS_TAG_RESET;
            st_reg.sdo <= cmsns_pkg::SDO_IDLE;
        end else begin
            st_reg <= st_next;
        end
    end

    assign s_axi_awready = !st_reg.aw_have && !st_reg.b_valid;
    assign s_axi_wready = !st_reg.w_have && !st_reg.b_valid;
    assign s_axi_bvalid = st_reg.b_valid;
    assign s_axi_bresp = st_reg.b_resp;
    assign s_axi_arready = !st_reg.r_valid;
    assign s_axi_rvalid = st_reg.r_valid;
    assign s_axi_rdata = st_reg.r_data;
    assign s_axi_rresp = st_reg.r_resp;

    assign sdo_req_valid = st_reg.req_valid;
    assign sdo_req_tag = st_reg.req[0][15:8];
    assign sdo_req_command = st_reg.req[0][7:0];
    assign sdo_req_size = st_reg.req[1][7:0];
    assign sdo_req_type = st_reg.req[2][15:8];
    assign sdo_req_node = st_reg.req[2][7:0];
    assign sdo_req_index = st_reg.req[3];
    assign sdo_req_subindex = st_reg.req[4][7:0];
    assign canopen_enabled = st_reg.enable;

    a_data_on_ok: assert property (@(posedge clock) disable iff (!rst_sync_b)
        st_reg.sdo == cmsns_pkg::SDO_WAIT && sdo_resp_valid && sdo_resp_status == 8'h01 && st_reg.enable
        |=> st_reg.resp[5] == $past(sdo_resp_data) && st_reg.resp[0][7:0] == 8'h01
            && st_reg.resp[3] == sdo_req_index)
        else $error("response words not loaded on success");
    a_resp_only_ok: assert property (@(posedge clock) disable iff (!rst_sync_b)
        $changed(st_reg.resp[5]) || $changed(st_reg.resp[2])
        |-> $past(st_reg.sdo) == cmsns_pkg::SDO_WAIT && $past(sdo_resp_valid) && $past(sdo_resp_status) == 8'h01)
        else $error("response data changed without a successful read");
    a_fail_keeps: assert property (@(posedge clock) disable iff (!rst_sync_b)
        st_reg.sdo == cmsns_pkg::SDO_WAIT && sdo_resp_valid && sdo_resp_status != 8'h01
        |=> $stable(st_reg.resp[1]) && st_reg.resp[0][7:0] != 8'h01 && st_reg.sdo == cmsns_pkg::SDO_IDLE)
        else $error("failed read touched the response body");
    a_tag_sends: assert property (@(posedge clock) disable iff (!rst_sync_b)
        $changed(st_reg.last_tag)
        |-> sdo_req_valid && sdo_req_tag == st_reg.last_tag && st_reg.sdo == cmsns_pkg::SDO_SEND)
        else $error("changed tag did not raise a request");
    a_ro_writes: assert property (@(posedge clock) disable iff (!rst_sync_b)
        st_reg.aw_have && st_reg.w_have && !st_reg.b_valid && wa == 9'h034 && st_reg.sdo == cmsns_pkg::SDO_IDLE
        |=> $stable(st_reg.resp[5]) ##1 s_axi_bresp == 2'b00 || !s_axi_bvalid)
        else $error("write changed a read-only word");

endmodule

/* bench/cmsns_sdo_slave.sv */
`timescale 1ns/1ps
module cmsns_sdo_slave (
    input  wire logic        clock,
    input  wire logic        req_valid,
    input  wire logic [3:0]  delay,
    input  wire logic        fail,
    output logic             req_ready,
    output logic             resp_valid,
    output logic [7:0]       status,
    output logic [7:0]       size,
    output logic [7:0]       rtype,
    output logic [15:0]      data
);
    logic       busy = 1'b0;
    logic [3:0] cnt  = 4'h0;
    initial begin
        req_ready = 1'b0;
        resp_valid = 1'b0;
        status = 8'h00;
        size = 8'h00;
        rtype = 8'h00;
        data = 16'h0000;
    end
    // Answer lines flip every cycle when not presenting
    always @(posedge clock) begin
        req_ready <= 1'b0;
        resp_valid <= 1'b0;
        status <= ~status;
        size <= ~size;
        rtype <= ~rtype;
        data <= ~data;
        if (!busy && req_valid && !req_ready) begin
            req_ready <= 1'b1;
            busy <= 1'b1;
            cnt <= delay;
        end else if (busy && !req_ready) begin
            if (cnt == 4'h0) begin
                resp_valid <= 1'b1;
                status <= fail ? 8'h05 : 8'h01;
                size <= 8'h08;
                rtype <= 8'h43;
                data <= 16'h0100;
                busy <= 1'b0;
            end else begin
                cnt <= cnt - 4'h1;
            end
        end
    end
endmodule

/* bench/canopen_master_sdo_node_status_test.sv */
`timescale 1ns/1ps
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("CHECK FAILED t=%0t got %h exp %h", $time, a, e); end end
module canopen_master_sdo_node_status_test;
    logic        clock = 1'b0, rst_b = 1'b0, awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
    logic        arvalid = 1'b0, rready = 1'b0, awready, wready, bvalid, arready, rvalid;
    logic        req_valid, req_ready, resp_valid, ev_valid = 1'b0, fail = 1'b0, enabled;
    logic [8:0]  awaddr = 9'h0, araddr = 9'h0;
    logic [31:0] wdata = 32'h0, rdata, d;
    logic [1:0]  bresp, rresp, r, b;
    logic [7:0]  st, sz, ty, rq_tag, rq_cmd, rq_size, rq_type, rq_node, rq_sub, ev_code = 8'h0;
    logic [15:0] rdat, rq_index, ex[6];
    logic [6:0]  ev_node = 7'h1;
    logic [3:0]  delay = 4'h0;
    logic [63:0] ef = 64'h0;
    int          n_errors = 0, checks_done = 0, nodes[9] = '{1, 16, 17, 32, 33, 48, 49, 63, 2};
    always #10 clock = ~clock;
    cmsns_top DUT (.clock(clock), .rst_b(rst_b), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .sdo_req_valid(req_valid),
        .sdo_req_ready(req_ready), .sdo_req_tag(rq_tag), .sdo_req_command(rq_cmd), .sdo_req_size(rq_size),
        .sdo_req_type(rq_type), .sdo_req_node(rq_node), .sdo_req_index(rq_index), .sdo_req_subindex(rq_sub),
        .sdo_resp_valid(resp_valid), .sdo_resp_status(st), .sdo_resp_size(sz), .sdo_resp_type(ty),
        .sdo_resp_data(rdat), .node_ev_valid(ev_valid), .node_ev_node(ev_node), .node_ev_code(ev_code),
        .node_configured(64'h7fff_ffff_ffff_ffff), .master_state_code(16'h00a5),
        .bit_rate_kbps(16'd250), .canopen_enabled(enabled));
    cmsns_sdo_slave PEER (.clock(clock), .req_valid(req_valid), .delay(delay), .fail(fail),
        .req_ready(req_ready), .resp_valid(resp_valid), .status(st), .size(sz), .rtype(ty), .data(rdat));
    task automatic wr(input logic [8:0] a, input logic [31:0] v);
        bit aw = 0, w = 0;
        @(posedge clock);
        awaddr <= a;
        wdata <= v;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (awvalid && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (wvalid && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (!bvalid);
        b = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [8:0] a);
        @(posedge clock);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do @(posedge clock); while (!arready);
        arvalid <= 1'b0;
        do @(posedge clock); while (!rvalid);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
    task automatic ev(input int n, input logic [7:0] c);
        @(posedge clock);
        ev_valid <= 1'b1;
        ev_node <= 7'(n);
        ev_code <= c;
        @(posedge clock);
        ev_valid <= 1'b0;
    endtask
    task automatic sdo(input logic [7:0] t, input logic [3:0] dl, input logic f);
        delay <= dl;
        fail <= f;
        wr(9'h004, 32'h4);
        wr(9'h008, 32'h0103);
        wr(9'h00c, 32'h2009);
        wr(9'h010, 32'h0);
        wr(9'h000, {16'h0, t, 8'h01});
        `CHK({req_valid, rq_tag, rq_node, rq_index}, {1'b1, t, 8'h03, 16'h2009})
        `CHK({rq_cmd, rq_size, rq_type, rq_sub}, {8'h01, 8'h04, 8'h01, 8'h00})
        do rd(9'h040); while (d[1]);
        ex = '{{t, f ? 8'h05 : 8'h01}, 16'h0008, 16'h4303, 16'h2009, 16'h0000, 16'h0100};
        for (int i = 0; i < 6; i++) begin
            rd(9'(32'h20 + 4 * i));
            `CHK(d, {16'h0, ex[i]})
        end
    endtask
    task end_sim;
        $display("errors %0d checks %0d", n_errors, checks_done);
        if (n_errors == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        #400000;
        n_errors++;
        end_sim;
    end
    initial begin
        repeat (2) @(posedge clock);
        rst_b <= 1'b1;
        repeat (3) @(posedge clock);
        wr(9'h048, 32'h55);
        `CHK(b, 2'b00)
        wr(9'h0f0, 32'h1);
        `CHK(b, 2'b10)
        rd(9'h048);
        `CHK(d, 32'h1)
        rd(9'h044);
        `CHK(d, 32'h0)
        rd(9'h04c);
        `CHK(d, 32'd250)
        rd(9'h0f0);
        `CHK(r, 2'b10)
        wr(9'h040, 32'h1);
        rd(9'h044);
        `CHK({enabled, d}, {1'b1, 32'h00a5})
        sdo(8'h01, 4'h0, 1'b0);
        sdo(8'h02, 4'h7, 1'b1);
        wr(9'h034, 32'hffff);
        `CHK(b, 2'b00)
        rd(9'h034);
        `CHK(d, 32'h0100)
        wr(9'h000, 32'h0201);
        `CHK(req_valid, 1'b0)
        delay <= 4'hf;
        wr(9'h000, 32'h0301);
        wr(9'h040, 32'h0);
        wr(9'h040, 32'h1);
        rd(9'h020);
        `CHK(d, 32'h0300)
        for (int i = 0; i < 9; i++) begin
            ev(nodes[i], 8'he0 + 8'(i));
            ef[nodes[i] - 1] = 1'b1;
            rd(9'(32'h100 + 4 * (nodes[i] - 1)));
            `CHK(d, 32'he0 + i)
        end
        ev(65, 8'he3);
        rd(9'h100);
        `CHK(d, 32'he0)
        ev(64, 8'he7);
        rd(9'h1fc);
        `CHK(d, 32'h0)
        ev(16, 8'h00);
        ef[15] = 1'b0;
        for (int k = 0; k < 4; k++) begin
            rd(9'(32'h50 + 4 * k));
            `CHK(d, {16'h0, ef[16 * k +: 16]})
        end
        wr(9'h040, 32'h0);
        rd(9'h100);
        `CHK(d, 32'h0)
        end_sim;
    end
endmodule
